// >>> hdl/cgi_device.sv
// Contract
// - read and write at up to 400 kb/s
// - write: start, address, rw, ack, pointer, data
// - later write bytes go to pointer plus one
// - full pointer byte after address, device acks low
// - device acks each data byte; stop ends write
// - master sets rw high to read
// - repeated start loads pointer, stores nothing
// - read address acked, byte at pointer shifted out
// - nack then stop: device releases data line
// - master ack: pointer increments, next byte sent
`timescale 1ns/1ps
`default_nettype none
module cgi_device #(
  parameter logic [cgi_pkg::ADDR_W-1:0] DEV_ADDR = cgi_pkg::DEF_DEV_ADDR,
  parameter int MEM_WORDS = cgi_pkg::MEM_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial link
  cgi_if.device bus,
  // store activity and frame in progress
  output logic memWrite,
  output logic [cgi_pkg::BYTE_W-1:0] memAddr,
  output logic [cgi_pkg::BYTE_W-1:0] memData,
  output logic frameActive
);
  import cgi_pkg::*;

  typedef struct packed {
    cgi_dev_state_t state;
    logic sclQ;
    logic sdaQ;
    logic [BYTE_W-1:0] shift;
    logic [BIT_CNT_W-1:0] cnt;
    logic rw;
    logic [BYTE_W-1:0] ptr;
    logic [BYTE_W-1:0] tx;
    logic drvLow;
    logic masterAck;
    logic wrPulse;
    logic [BYTE_W-1:0] wrAddr;
    logic [BYTE_W-1:0] wrData;
    logic active;
  } cgi_dev_reg_t;

  cgi_dev_reg_t s;
  cgi_dev_reg_t next_s;
  logic [BYTE_W-1:0] mem [MEM_WORDS];
  logic [1:0] syncOut;
  logic sclS;
  logic sdaS;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  // link pins pass two flops; sampled at 20 MHz, fine for 400 kb/s
  cgi_sync #(
    .WIDTH(2)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din({bus.scl, bus.sda}),
    .dout(syncOut)
  );

  assign sclS = syncOut[1];
  assign sdaS = syncOut[0];
  assign sclRise = sclS && !s.sclQ;
  assign sclFall = !sclS && s.sclQ;
  assign startSeen = sclS && s.sclQ && s.sdaQ && !sdaS;
  assign stopSeen = sclS && s.sclQ && !s.sdaQ && sdaS;

  always_comb
  begin
    next_s = s;
    next_s.sclQ = sclS;
    next_s.sdaQ = sdaS;
    next_s.wrPulse = 1'b0;
    if (startSeen)
    begin
      // a repeated start keeps the pointer just loaded
      next_s.state = DS_ADDR;
      next_s.cnt = '0;
      next_s.drvLow = 1'b0;
      next_s.active = 1'b1;
    end
    else if (stopSeen)
    begin
      // stop ends any frame and frees the data line
      next_s.state = DS_IDLE;
      next_s.drvLow = 1'b0;
      next_s.active = 1'b0;
    end
    else
    begin
      unique case (s.state)
        DS_IDLE:
        begin
          next_s.drvLow = 1'b0;
        end
        DS_ADDR:
        begin
          if (sclRise)
          begin
            next_s.shift = {s.shift[BYTE_W-2:0], sdaS};
            next_s.cnt = s.cnt + BIT_STEP;
          end
          else if (sclFall && s.cnt == BITS_PER_BYTE)
          begin
            if (s.shift[BYTE_W-1:1] == DEV_ADDR)
            begin
              next_s.drvLow = 1'b1;
              next_s.rw = s.shift[0];
              next_s.state = DS_ADDR_ACK;
            end
            else
            begin
              next_s.state = DS_IDLE;
              next_s.active = 1'b0;
            end
          end
        end
        DS_ADDR_ACK:
        begin
          if (sclFall)
          begin
            next_s.cnt = '0;
            if (s.rw == RW_READ)
            begin
              next_s.tx = mem[s.ptr];
              next_s.drvLow = !mem[s.ptr][BYTE_W-1];
              next_s.state = DS_RDATA;
            end
            else
            begin
              next_s.drvLow = 1'b0;
              next_s.state = DS_REG;
            end
          end
        end
        DS_REG:
        begin
          if (sclRise)
          begin
            next_s.shift = {s.shift[BYTE_W-2:0], sdaS};
            next_s.cnt = s.cnt + BIT_STEP;
          end
          else if (sclFall && s.cnt == BITS_PER_BYTE)
          begin
            next_s.ptr = s.shift;
            next_s.drvLow = 1'b1;
            next_s.state = DS_REG_ACK;
          end
        end
        DS_REG_ACK:
        begin
          if (sclFall)
          begin
            next_s.drvLow = 1'b0;
            next_s.cnt = '0;
            next_s.state = DS_WDATA;
          end
        end
        DS_WDATA:
        begin
          if (sclRise)
          begin
            next_s.shift = {s.shift[BYTE_W-2:0], sdaS};
            next_s.cnt = s.cnt + BIT_STEP;
          end
          else if (sclFall && s.cnt == BITS_PER_BYTE)
          begin
            next_s.wrPulse = 1'b1;
            next_s.wrAddr = s.ptr;
            next_s.wrData = s.shift;
            next_s.ptr = s.ptr + PTR_STEP;
            next_s.drvLow = 1'b1;
            next_s.state = DS_WDATA_ACK;
          end
        end
        DS_WDATA_ACK:
        begin
          if (sclFall)
          begin
            next_s.drvLow = 1'b0;
            next_s.cnt = '0;
            next_s.state = DS_WDATA;
          end
        end
        DS_RDATA:
        begin
          if (sclFall)
          begin
            next_s.cnt = s.cnt + BIT_STEP;
            if (s.cnt + BIT_STEP == BITS_PER_BYTE)
            begin
              // release for the master's acknowledge bit
              next_s.drvLow = 1'b0;
              next_s.state = DS_RACK;
            end
            else
            begin
              next_s.drvLow = !s.tx[BYTE_W-2];
              next_s.tx = {s.tx[BYTE_W-2:0], 1'b0};
            end
          end
        end
        DS_RACK:
        begin
          if (sclRise)
          begin
            next_s.masterAck = (sdaS == ACK_BIT);
          end
          else if (sclFall)
          begin
            next_s.cnt = '0;
            if (s.masterAck)
            begin
              next_s.ptr = s.ptr + PTR_STEP;
              next_s.tx = mem[next_s.ptr];
              next_s.drvLow = !mem[next_s.ptr][BYTE_W-1];
              next_s.state = DS_RDATA;
            end
            else
            begin
              next_s.drvLow = 1'b0;
              next_s.state = DS_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // configuration memory, no reset
  always_ff @(posedge ref_clk)
  begin
    if (s.wrPulse)
    begin
      mem[s.wrAddr] <= s.wrData;
    end
  end

  assign bus.devSdaOut = 1'b0;
  assign bus.devSdaOe = s.drvLow;
  assign memWrite = s.wrPulse;
  assign memAddr = s.wrAddr;
  assign memData = s.wrData;
  assign frameActive = s.active;
endmodule // cgi_device
`default_nettype wire

// >>> hdl/cgi_pkg.sv
`default_nettype none
package cgi_pkg;
  localparam int ADDR_W = 7;
  localparam int BYTE_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX = 4'h8;
  localparam logic [BIT_CNT_W-1:0] BIT_STEP = 4'h1;
  localparam logic [BYTE_W-1:0] PTR_STEP = 8'h01;
  localparam logic [BYTE_W-1:0] LEN_ONE = 8'h01;
  localparam logic [BYTE_W-1:0] LEN_TWO = 8'h02;
  localparam logic [BYTE_W-1:0] RELEASE_BYTE = 8'hff;
  // slave address value is arbitrary
  localparam logic [ADDR_W-1:0] DEF_DEV_ADDR = 7'h5a;
  localparam logic RW_WRITE = 1'b0;
  localparam logic RW_READ = 1'b1;
  localparam logic ACK_BIT = 1'b0;
  localparam logic NACK_BIT = 1'b1;
  // bus timing: fastest rate gives the shortest legal clock period
  localparam int BUS_RATE_KBPS = 400;
  localparam int SCL_PERIOD_NS = 1000000 / BUS_RATE_KBPS;
  localparam int CLK_PERIOD_NS = 50;
  localparam int QUARTER_CYCLES =
    (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
  localparam int DIV_W = 8;

  typedef enum logic [3:0] {
    DS_IDLE, DS_ADDR, DS_ADDR_ACK, DS_REG, DS_REG_ACK,
    DS_WDATA, DS_WDATA_ACK, DS_RDATA, DS_RACK
  } cgi_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE, HS_START, HS_XFER, HS_RESTART, HS_STOP
  } cgi_host_state_t;

  typedef enum logic [2:0] {
    HP_DEV, HP_REG, HP_WDATA, HP_DEVR, HP_RDATA
  } cgi_step_t;
endpackage
`default_nettype wire

// >>> hdl/cgi_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cgi_if;
  logic sclOut;
  logic sclOe;
  logic hostSdaOut;
  logic hostSdaOe;
  logic devSdaOut;
  logic devSdaOe;
  logic scl;
  logic sda;

  // open-drain wires with pull-up
  assign scl = !(sclOe && !sclOut);
  assign sda = !((hostSdaOe && !hostSdaOut) || (devSdaOe && !devSdaOut));

  modport device (input scl, input sda, output devSdaOut, output devSdaOe);
  modport host (input scl, input sda, output sclOut, output sclOe,
                output hostSdaOut, output hostSdaOe);
endinterface
`default_nettype wire

// >>> hdl/cgi_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cgi_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // async in, synced out
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } cgi_sync_state_t;

  cgi_sync_state_t s;
  cgi_sync_state_t next_s;

  always_comb
  begin
    next_s.first = din;
    next_s.second = s.first;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign dout = s.second;
endmodule // cgi_sync
`default_nettype wire

// >>> hdl/cgi_host.sv
`timescale 1ns/1ps
`default_nettype none
module cgi_host #(
  parameter int QUARTER = cgi_pkg::QUARTER_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // serial link
  cgi_if.host bus,
  // command
  input wire logic cmdValid,
  input wire logic cmdRead,
  input wire logic [cgi_pkg::ADDR_W-1:0] cmdDevAddr,
  input wire logic [cgi_pkg::BYTE_W-1:0] cmdRegAddr,
  input wire logic [cgi_pkg::BYTE_W-1:0] cmdLen,
  // write data
  input wire logic [cgi_pkg::BYTE_W-1:0] txData,
  output logic txTake,
  // read data
  output logic rxValid,
  output logic [cgi_pkg::BYTE_W-1:0] rxData,
  // status
  output logic busy,
  output logic done,
  output logic nackErr
);
  import cgi_pkg::*;

  localparam logic [DIV_W-1:0] DIV_LOAD = DIV_W'(QUARTER - 1);

  typedef struct packed {
    cgi_host_state_t state;
    cgi_step_t step;
    logic [1:0] phase;
    logic [DIV_W-1:0] div;
    logic [BIT_CNT_W-1:0] bitIdx;
    logic [BYTE_W:0] tx;
    logic [BYTE_W:0] rx;
    logic rd;
    logic [ADDR_W-1:0] devAddr;
    logic [BYTE_W-1:0] regAddr;
    logic [BYTE_W-1:0] remain;
    logic sclLow;
    logic sdaLow;
    logic busy;
    logic done;
    logic nackErr;
    logic txTake;
    logic rxValid;
    logic [BYTE_W-1:0] rxData;
  } cgi_host_reg_t;

  cgi_host_reg_t s;
  cgi_host_reg_t next_s;
  logic sdaS;
  logic tick;
  logic nacked;

  cgi_sync #(
    .WIDTH(1)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(bus.sda),
    .dout(sdaS)
  );

  assign tick = (s.div == '0);
  assign nacked = (s.rx[0] == NACK_BIT);

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.txTake = 1'b0;
    next_s.rxValid = 1'b0;
    next_s.div = tick ? DIV_LOAD : s.div - 1'b1;
    if (s.state == HS_IDLE)
    begin
      next_s.div = DIV_LOAD;
      next_s.phase = '0;
      next_s.sclLow = 1'b0;
      next_s.sdaLow = 1'b0;
      if (cmdValid)
      begin
        next_s.state = HS_START;
        next_s.busy = 1'b1;
        next_s.nackErr = 1'b0;
        next_s.rd = cmdRead;
        next_s.devAddr = cmdDevAddr;
        next_s.regAddr = cmdRegAddr;
        next_s.remain = (cmdRead && cmdLen == '0) ? LEN_ONE : cmdLen;
        next_s.step = HP_DEV;
        next_s.tx = {cmdDevAddr, RW_WRITE, NACK_BIT};
        next_s.bitIdx = '0;
      end
    end
    else if (tick)
    begin
      next_s.phase = s.phase + 2'h1;
      unique case (s.state)
        HS_IDLE:
        begin
          next_s.state = HS_IDLE;
        end
        HS_START:
        begin
          if (s.phase == 2'h1) next_s.sdaLow = 1'b1;
          if (s.phase == 2'h2) next_s.sclLow = 1'b1;
          if (s.phase == 2'h3) next_s.state = HS_XFER;
        end
        HS_RESTART:
        begin
          if (s.phase == 2'h0) next_s.sdaLow = 1'b0;
          if (s.phase == 2'h1) next_s.sclLow = 1'b0;
          if (s.phase == 2'h2) next_s.sdaLow = 1'b1;
          if (s.phase == 2'h3)
          begin
            next_s.sclLow = 1'b1;
            next_s.state = HS_XFER;
            next_s.step = HP_DEVR;
            next_s.tx = {s.devAddr, RW_READ, NACK_BIT};
          end
        end
        HS_STOP:
        begin
          if (s.phase == 2'h0) next_s.sdaLow = 1'b1;
          if (s.phase == 2'h1) next_s.sclLow = 1'b0;
          if (s.phase == 2'h2) next_s.sdaLow = 1'b0;
          if (s.phase == 2'h3)
          begin
            next_s.state = HS_IDLE;
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
          end
        end
        HS_XFER:
        begin
          if (s.phase == 2'h0) next_s.sdaLow = !s.tx[BYTE_W];
          if (s.phase == 2'h1) next_s.sclLow = 1'b0;
          if (s.phase == 2'h2) next_s.rx = {s.rx[BYTE_W-1:0], sdaS};
          if (s.phase == 2'h3)
          begin
            next_s.sclLow = 1'b1;
            if (s.bitIdx != LAST_BIT_IDX)
            begin
              next_s.bitIdx = s.bitIdx + BIT_STEP;
              next_s.tx = {s.tx[BYTE_W-1:0], NACK_BIT};
            end
            else
            begin
              next_s.bitIdx = '0;
              next_s.state = HS_STOP;
              unique case (s.step)
                HP_DEV, HP_DEVR, HP_REG, HP_WDATA:
                begin
                  if (nacked)
                  begin
                    next_s.nackErr = 1'b1;
                  end
                  else if (s.step == HP_DEV)
                  begin
                    next_s.state = HS_XFER;
                    next_s.step = HP_REG;
                    next_s.tx = {s.regAddr, NACK_BIT};
                  end
                  else if (s.step == HP_DEVR)
                  begin
                    next_s.state = HS_XFER;
                    next_s.step = HP_RDATA;
                    next_s.tx = {RELEASE_BYTE, s.remain == LEN_ONE};
                  end
                  else if (s.step == HP_REG && s.rd)
                  begin
                    next_s.state = HS_RESTART;
                  end
                  else
                  begin
                    if (s.step == HP_WDATA)
                    begin
                      next_s.remain = s.remain - PTR_STEP;
                    end
                    if (next_s.remain != '0)
                    begin
                      next_s.state = HS_XFER;
                      next_s.step = HP_WDATA;
                      next_s.tx = {txData, NACK_BIT};
                      next_s.txTake = 1'b1;
                    end
                  end
                end
                HP_RDATA:
                begin
                  next_s.rxValid = 1'b1;
                  next_s.rxData = s.rx[BYTE_W:1];
                  next_s.remain = s.remain - PTR_STEP;
                  if (s.remain != LEN_ONE)
                  begin
                    next_s.state = HS_XFER;
                    next_s.tx = {RELEASE_BYTE, s.remain == LEN_TWO};
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign bus.sclOut = 1'b0;
  assign bus.sclOe = s.sclLow;
  assign bus.hostSdaOut = 1'b0;
  assign bus.hostSdaOe = s.sdaLow;
  assign txTake = s.txTake;
  assign rxValid = s.rxValid;
  assign rxData = s.rxData;
  assign busy = s.busy;
  assign done = s.done;
  assign nackErr = s.nackErr;
endmodule // cgi_host
`default_nettype wire

// >>> testbench/cgi_properties.sv
`timescale 1ns/1ps
`default_nettype none
module cgi_properties #(
  parameter int QUARTER = 13
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // link drives and resolved wires
  input wire logic sclOut,
  input wire logic sclOe,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic scl,
  input wire logic sda
);
  localparam int START_MAX = 2 * QUARTER + 4;
  // 2500 ns shortest bit at 50 ns clock
  localparam logic [7:0] MIN_PERIOD = 8'h32;
  logic sclQ;
  logic [7:0] sinceRise;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // cycles between scl rises, saturating
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      sclQ <= 1'b1;
      sinceRise <= 8'h00;
    end
    else
    begin
      sclQ <= scl;
      if (scl && !sclQ)
        sinceRise <= 8'h01;
      else if (sinceRise != 8'h00 && sinceRise != 8'hff)
        sinceRise <= sinceRise + 8'h01;
    end
  end

  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence

  property p_open_drain;
    !sclOut && !hostSdaOut && !devSdaOut;
  endproperty
  property p_dev_change_low;
    $changed(devSdaOe) |-> !scl;
  endproperty
  property p_one_driver;
    $rose(scl) |-> !(devSdaOe && hostSdaOe);
  endproperty
  property p_start_clock;
    s_start |-> ##[1:START_MAX] !scl;
  endproperty
  property p_stop_release;
    s_stop |=> !devSdaOe [*8];
  endproperty
  property p_bit_rate;
    scl && !sclQ && sinceRise != 8'h00 |-> sinceRise >= MIN_PERIOD;
  endproperty
  property p_low_len;
    $fell(scl) |-> !scl [*8];
  endproperty
  property p_dev_hold;
    $rose(scl) && devSdaOe |-> devSdaOe [*8];
  endproperty

  a_open_drain: assert property (p_open_drain)
    else $error("line driven high");
  a_dev_change_low: assert property (p_dev_change_low)
    else $error("device data changed with clock high");
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive data");
  a_start_clock: assert property (p_start_clock)
    else $error("no clock after start");
  a_stop_release: assert property (p_stop_release)
    else $error("device drives after stop");
  a_bit_rate: assert property (p_bit_rate)
    else $error("bit rate too high");
  a_low_len: assert property (p_low_len)
    else $error("clock low too short");
  a_dev_hold: assert property (p_dev_hold)
    else $error("device drive dropped with clock high");
endmodule // cgi_properties
`default_nettype wire

// >>> testbench/clock_gen_i2c_register_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module clock_gen_i2c_register_port_tb_top;
  import cgi_pkg::*;
  localparam int TOUT = 5000;
  localparam logic [ADDR_W-1:0] OTHER = DEF_DEV_ADDR ^ 7'h01;
  logic ref_clk;
  logic rst;
  logic cmdValid, cmdRead;
  logic [ADDR_W-1:0] cmdDevAddr;
  logic [BYTE_W-1:0] cmdRegAddr, cmdLen, txData, rxData, memAddr, memData;
  logic txTake, rxValid, busy, done, nackErr, memWrite, frameActive;
  // set once the device has reported a frame in progress
  logic sawActive;
  logic [BYTE_W-1:0] pat [3] = '{8'ha5, 8'h3c, 8'hc3};
  logic [BYTE_W-1:0] txQ[$], rxQ[$], wAddrQ[$], wDataQ[$];
  int badCount, checked;

  cgi_if i_cgi_if ();
  cgi_device i_cgi_device (.ref_clk(ref_clk), .rst(rst), .bus(i_cgi_if),
    .memWrite(memWrite), .memAddr(memAddr), .memData(memData),
    .frameActive(frameActive));
  cgi_host #(.QUARTER(QUARTER_CYCLES)) i_cgi_host (.ref_clk(ref_clk),
    .rst(rst), .bus(i_cgi_if), .cmdValid(cmdValid), .cmdRead(cmdRead),
    .cmdDevAddr(cmdDevAddr), .cmdRegAddr(cmdRegAddr), .cmdLen(cmdLen),
    .txData(txData), .txTake(txTake), .rxValid(rxValid), .rxData(rxData),
    .busy(busy), .done(done), .nackErr(nackErr));
  cgi_properties #(.QUARTER(QUARTER_CYCLES)) i_cgi_properties (
    .ref_clk(ref_clk), .rst(rst), .sclOut(i_cgi_if.sclOut),
    .sclOe(i_cgi_if.sclOe), .hostSdaOut(i_cgi_if.hostSdaOut),
    .hostSdaOe(i_cgi_if.hostSdaOe), .devSdaOut(i_cgi_if.devSdaOut),
    .devSdaOe(i_cgi_if.devSdaOe), .scl(i_cgi_if.scl), .sda(i_cgi_if.sda));

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpBit(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic wrapUp();
    if (badCount == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one host command; collects read bytes and device stores
  task automatic xfer(input logic rd, input logic [6:0] dev,
    input logic [7:0] ra, input logic [7:0] len);
    int n;
    n = 0;
    sawActive = 1'b0;
    rxQ = {};
    wAddrQ = {};
    wDataQ = {};
    do @(negedge ref_clk); while (busy !== 1'b0);
    @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdRead <= rd;
    cmdDevAddr <= dev;
    cmdRegAddr <= ra;
    cmdLen <= len;
    txData <= (txQ.size() > 0) ? txQ.pop_front() : 8'h00;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    do
    begin
      @(negedge ref_clk);
      n++;
      if (frameActive === 1'b1)
        sawActive = 1'b1;
      if (rxValid === 1'b1)
        rxQ.push_back(rxData);
      if (memWrite === 1'b1)
      begin
        wAddrQ.push_back(memAddr);
        wDataQ.push_back(memData);
      end
      if (txTake === 1'b1 && txQ.size() > 0)
      begin
        @(posedge ref_clk);
        txData <= txQ.pop_front();
      end
    end
    while (done !== 1'b1 && n < TOUT);
    if (n >= TOUT)
    begin
      badCount++;
      $display("mismatch at %0t: command never finished", $time);
    end
  endtask

  task automatic t_reset();
    @(negedge ref_clk);
    cmpBit(i_cgi_if.scl & i_cgi_if.sda, 1'b1);
    cmpBit(frameActive | busy | memWrite, 1'b0);
  endtask
  task automatic t_seq_write();
    txQ = {pat[0], pat[1], pat[2]};
    xfer(RW_WRITE, DEF_DEV_ADDR, 8'hfe, 8'h03);
    cmp8(8'(wAddrQ.size()), 8'h03);
    cmpBit(sawActive, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      cmp8(wAddrQ[i], 8'hfe + 8'(i));
      cmp8(wDataQ[i], pat[i]);
    end
    cmpBit(nackErr, 1'b0);
  endtask
  task automatic t_random_read();
    xfer(RW_READ, DEF_DEV_ADDR, 8'hff, 8'h01);
    cmp8(8'(rxQ.size()), 8'h01);
    cmp8(rxQ[0], pat[1]);
    cmp8(8'(wAddrQ.size()), 8'h00);
    cmpBit(nackErr, 1'b0);
  endtask
  task automatic t_seq_read();
    xfer(RW_READ, DEF_DEV_ADDR, 8'hfe, 8'h03);
    cmp8(8'(rxQ.size()), 8'h03);
    for (int i = 0; i < 3; i++)
      cmp8(rxQ[i], pat[i]);
    @(negedge ref_clk);
    cmpBit(i_cgi_if.devSdaOe | frameActive, 1'b0);
    cmpBit(i_cgi_if.sda, 1'b1);
  endtask
  task automatic t_pointer_only();
    xfer(RW_WRITE, DEF_DEV_ADDR, 8'h00, 8'h00);
    cmp8(8'(wAddrQ.size()), 8'h00);
    cmpBit(nackErr, 1'b0);
    xfer(RW_READ, DEF_DEV_ADDR, 8'h00, 8'h00);
    cmp8(8'(rxQ.size()), 8'h01);
    cmp8(rxQ[0], pat[2]);
  endtask
  task automatic t_foreign();
    txQ = {8'h77};
    xfer(RW_WRITE, OTHER, 8'h00, 8'h01);
    cmpBit(nackErr, 1'b1);
    cmp8(8'(wAddrQ.size()), 8'h00);
    cmpBit(frameActive, 1'b0);
    xfer(RW_READ, OTHER, 8'h00, 8'h01);
    cmpBit(nackErr, 1'b1);
    xfer(RW_READ, DEF_DEV_ADDR, 8'h00, 8'h01);
    cmp8(rxQ[0], pat[2]);
    cmpBit(nackErr, 1'b0);
  endtask

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // watchdog sized well above the sum of all frames
  initial
  begin
    repeat (60000) @(posedge ref_clk);
    badCount++;
    $display("mismatch at %0t: watchdog expired", $time);
    wrapUp();
  end

  initial
  begin
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdRead = 1'b0;
    cmdDevAddr = 7'h00;
    cmdRegAddr = 8'h00;
    cmdLen = 8'h00;
    txData = 8'h00;
    badCount = 0;
    checked = 0;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_seq_write();
    t_random_read();
    t_seq_read();
    t_pointer_only();
    t_foreign();
    wrapUp();
  end
endmodule // clock_gen_i2c_register_port_tb_top
`default_nettype wire
